// ==== src/msc_regs.svh ====
// timing counts, reset values and field positions of the module sideband control
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH

`define MSC_CLK_PERIOD_NS      10
`define MSC_RESET_MIN_NS       10000
`define MSC_RESET_MIN_CYC      ((`MSC_RESET_MIN_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)
`define MSC_INIT_NS            2000
`define MSC_INIT_CYC           ((`MSC_INIT_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)
`define MSC_LANES              4
`define MSC_MON_WIDTH          8
`define MSC_RST_SOFT_TXDIS     4'h0
`define MSC_RST_POWER_CLASS    2'h3
`define MSC_LOW_POWER_CLASS    2'h0
`define MSC_CTRL_TXDIS_LSB     0
`define MSC_CTRL_HIPWR_BIT     4

`endif

// ==== src/msc_pkg.sv ====
// types shared by the module sideband control
package msc_pkg;
    typedef enum logic [1:0] {
        MSC_ST_POWERUP = 2'b00,
        MSC_ST_RUN     = 2'b01,
        MSC_ST_HOLD    = 2'b10,
        MSC_ST_INIT    = 2'b11
    } msc_state_e;
    typedef logic [1:0] msc_pwr_t;
endpackage

// ==== src/msc_pulse_filter.sv ====
// counts how long a level stays low and flags when it passed the minimum
`timescale 1ns/1ps
`default_nettype none
module msc_pulse_filter #(
    parameter int MIN_CYC = 1000
) (
    input  wire logic clk,      // system clock
    input  wire logic reset_n,  // async reset
    input  wire logic level_n,  // watched active-low level
    output logic      long_low  // low held past minimum
);
    localparam int CW = $clog2(MIN_CYC + 1);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          long_ff;
    logic          nxt_long;

    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_long = 1'b0;
        if (level_n) begin
            nxt_cnt = '0;
        end else if (cnt_ff < CW'(MIN_CYC)) begin
            nxt_cnt = cnt_ff + CW'(1);
        end
        if (!level_n && cnt_ff >= CW'(MIN_CYC)) begin
            nxt_long = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff  <= '0;
            long_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            long_ff <= nxt_long;
        end
    end

    assign long_low = long_ff;
endmodule
`default_nettype wire

// ==== src/msc_lane_monitor.sv ====
// one received lane: loss flag against a threshold and the latest monitored value
`timescale 1ns/1ps
`default_nettype none
module msc_lane_monitor #(
    parameter int W = 8
) (
    input  wire logic         clk,        // system clock
    input  wire logic         reset_n,    // async reset
    input  wire logic [W-1:0] level,      // sampled lane level
    input  wire logic [W-1:0] threshold,  // loss threshold
    output logic              lost,       // level below threshold
    output logic [W-1:0]      value       // held monitored value
);
    logic [W-1:0] val_ff;
    logic [W-1:0] nxt_val;
    logic         lost_ff;
    logic         nxt_lost;

    always_comb begin
        nxt_val  = level;
        nxt_lost = (level < threshold);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            val_ff  <= '0;
            lost_ff <= 1'b1;
        end else begin
            val_ff  <= nxt_val;
            lost_ff <= nxt_lost;
        end
    end

    assign lost  = lost_ff;
    assign value = val_ff;
endmodule
`default_nettype wire

// ==== src/msc_sideband.sv ====
// low-speed sideband control of a four-lane pluggable module
//
// Overview of operation
// - serial commands are taken only while the select input is held low.
// - a reset input held low past the minimum length resets every setting to default.
// - at the end of a reset the interrupt is asserted and data-not-ready is cleared.
// - after power-up the completion interrupt is posted without any reset pulse.
// - the low-power input caps the allowed power class of the module.
// - an inserted module pulls its presence output low.
// - the interrupt output goes low for faults or critical status.
// - the transmitter is off when the disable pin or the serial command asks for it.
// - the loss alarm rises when any of the four lanes falls below threshold.
// - every lane is monitored and its value is presented on the diagnostic_monitor output.
// - the sideband has select, decoded serial strobes, reset, low-power, presence and interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "msc_regs.svh"
module msc_sideband
    import msc_pkg::*;
#(
    parameter int LANES     = `MSC_LANES,
    parameter int MW        = `MSC_MON_WIDTH,
    parameter int RESET_CYC = `MSC_RESET_MIN_CYC,
    parameter int INIT_CYC  = `MSC_INIT_CYC
) (
    input  wire logic                clk,                // system clock
    input  wire logic                reset_n,            // async reset
    input  wire logic                module_select_n,    // host select, low active
    input  wire logic                module_reset_n,     // host reset pin, low active
    input  wire logic                low_power_select,   // low-power mode pin
    input  wire logic                transmit_disable,   // hardware tx disable pin
    input  wire logic                ser_wr_stb,         // decoded serial write pulse
    input  wire logic                ser_rd_stb,         // decoded serial read pulse
    input  wire logic [4:0]          ser_wdata,          // serial write: txdis lanes, hi power
    input  wire logic                ser_int_clr,        // serial clear of interrupt cause
    input  wire logic [LANES*MW-1:0] lane_level,         // sampled received lane levels
    input  wire logic [MW-1:0]       loss_threshold,     // loss threshold level
    input  wire logic                fault_in,           // operational fault from optics
    output logic                     ser_ack,            // command accepted while selected
    output logic [LANES*MW-1:0]      diagnostic_monitor, // monitored lane values
    output logic [7:0]               ser_status,         // status byte for serial reads
    output logic                     data_not_ready,     // memory-map data-not-ready flag
    output logic                     module_present_n,   // presence, low when inserted
    output logic                     interrupt_n,        // interrupt, low active
    output logic                     interrupt_oe,       // open-drain enable of interrupt
    output logic [LANES-1:0]         tx_off,             // per-lane transmitter off
    output logic                     receive_loss_alarm, // any lane lost
    output msc_pwr_t                 power_class         // permitted power class
);
    ////////////////////////////////////////////////////////////////////////////////////////
    // reset pulse qualification
    logic long_low;

    msc_pulse_filter #(.MIN_CYC(RESET_CYC)) u_rst_filter (
        .clk      (clk),
        .reset_n  (reset_n),
        .level_n  (module_reset_n),
        .long_low (long_low)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // lane monitors
    logic [LANES-1:0]    lane_lost;
    logic [LANES*MW-1:0] lane_value;

    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            msc_lane_monitor #(.W(MW)) u_mon (
                .clk       (clk),
                .reset_n   (reset_n),
                .level     (lane_level[gi*MW +: MW]),
                .threshold (loss_threshold),
                .lost      (lane_lost[gi]),
                .value     (lane_value[gi*MW +: MW])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////
    // state machine and settings
    localparam int IW = $clog2(INIT_CYC + 1);

    msc_state_e       state_ff;
    msc_state_e       nxt_state;
    logic [IW-1:0]    init_cnt_ff;
    logic [IW-1:0]    nxt_init_cnt;
    logic [LANES-1:0] soft_txdis_ff;
    logic [LANES-1:0] nxt_soft_txdis;
    logic             hipwr_ff;
    logic             nxt_hipwr;
    logic             dnr_ff;
    logic             nxt_dnr;
    logic             done_int_ff;
    logic             nxt_done_int;
    logic             fault_int_ff;
    logic             nxt_fault_int;
    logic             loss_prev_ff;
    logic             nxt_loss_prev;
    logic             ack_ff;
    logic             nxt_ack;
    logic             selected;
    logic             loss_any;

    assign selected = !module_select_n && state_ff == MSC_ST_RUN;
    assign loss_any = |lane_lost;

    always_comb begin
        nxt_state      = state_ff;
        nxt_init_cnt   = init_cnt_ff;
        nxt_soft_txdis = soft_txdis_ff;
        nxt_hipwr      = hipwr_ff;
        nxt_dnr        = dnr_ff;
        nxt_done_int   = done_int_ff;
        nxt_fault_int  = fault_int_ff;
        nxt_loss_prev  = loss_any;
        nxt_ack        = 1'b0;
        case (state_ff)
            MSC_ST_POWERUP: begin
                nxt_state    = MSC_ST_INIT;
                nxt_init_cnt = '0;
            end
            MSC_ST_RUN: begin
                if (long_low) begin
                    nxt_state = MSC_ST_HOLD;
                end else if (selected && (ser_wr_stb || ser_rd_stb)) begin
                    nxt_ack = 1'b1;
                    if (ser_wr_stb) begin
                        nxt_soft_txdis = ser_wdata[`MSC_CTRL_TXDIS_LSB +: LANES];
                        nxt_hipwr      = ser_wdata[`MSC_CTRL_HIPWR_BIT];
                    end
                    if (ser_int_clr) begin
                        nxt_done_int  = 1'b0;
                        nxt_fault_int = 1'b0;
                    end
                end
            end
            MSC_ST_HOLD: begin
                nxt_soft_txdis = `MSC_RST_SOFT_TXDIS;
                nxt_hipwr      = 1'b0;
                nxt_dnr        = 1'b1;
                nxt_done_int   = 1'b0;
                nxt_fault_int  = 1'b0;
                if (module_reset_n) begin
                    nxt_state    = MSC_ST_INIT;
                    nxt_init_cnt = '0;
                end
            end
            MSC_ST_INIT: begin
                nxt_init_cnt = init_cnt_ff + IW'(1);
                if (init_cnt_ff >= IW'(INIT_CYC - 1)) begin
                    nxt_state    = MSC_ST_RUN;
                    nxt_dnr      = 1'b0;
                    nxt_done_int = 1'b1;
                end
            end
            default: begin
                nxt_state = MSC_ST_POWERUP;
            end
        endcase
        // a fault arriving with the clear wins
        if (state_ff == MSC_ST_RUN && (fault_in || (loss_any && !loss_prev_ff))) begin
            nxt_fault_int = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff      <= MSC_ST_POWERUP;
            init_cnt_ff   <= '0;
            soft_txdis_ff <= `MSC_RST_SOFT_TXDIS;
            hipwr_ff      <= 1'b0;
            dnr_ff        <= 1'b1;
            done_int_ff   <= 1'b0;
            fault_int_ff  <= 1'b0;
            loss_prev_ff  <= 1'b0;
            ack_ff        <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            init_cnt_ff   <= nxt_init_cnt;
            soft_txdis_ff <= nxt_soft_txdis;
            hipwr_ff      <= nxt_hipwr;
            dnr_ff        <= nxt_dnr;
            done_int_ff   <= nxt_done_int;
            fault_int_ff  <= nxt_fault_int;
            loss_prev_ff  <= nxt_loss_prev;
            ack_ff        <= nxt_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // registered pin outputs
    logic [LANES-1:0] tx_off_ff;
    logic [LANES-1:0] nxt_tx_off;
    logic             int_ff;
    logic             nxt_int;
    logic             alarm_ff;
    logic             nxt_alarm;
    msc_pwr_t         pwr_ff;
    msc_pwr_t         nxt_pwr;
    logic [7:0]       status_ff;
    logic [7:0]       nxt_status;
    logic             pin_low_ff;

    always_comb begin
        nxt_tx_off = soft_txdis_ff | {LANES{transmit_disable}} |
                     {LANES{state_ff != MSC_ST_RUN}};
        nxt_int    = nxt_done_int || nxt_fault_int;
        nxt_alarm  = loss_any;
        if (low_power_select || !hipwr_ff) begin
            nxt_pwr = `MSC_LOW_POWER_CLASS;
        end else begin
            nxt_pwr = `MSC_RST_POWER_CLASS;
        end
        nxt_status = {dnr_ff, done_int_ff, fault_int_ff, loss_any, lane_lost};
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_off_ff  <= '1;
            int_ff     <= 1'b0;
            alarm_ff   <= 1'b1;                                    // lanes count as lost in reset
            pwr_ff     <= `MSC_LOW_POWER_CLASS;
            status_ff  <= 8'h00;
            pin_low_ff <= 1'b0;
        end else begin
            tx_off_ff  <= nxt_tx_off;
            int_ff     <= nxt_int;
            alarm_ff   <= nxt_alarm;
            pwr_ff     <= nxt_pwr;
            status_ff  <= nxt_status;
            pin_low_ff <= 1'b0;
        end
    end

    assign ser_ack            = ack_ff;
    assign diagnostic_monitor = lane_value;
    assign ser_status         = status_ff;
    assign data_not_ready     = dnr_ff;
    assign module_present_n   = pin_low_ff;
    assign interrupt_n        = pin_low_ff;
    assign interrupt_oe       = int_ff;
    assign tx_off             = tx_off_ff;
    assign receive_loss_alarm = alarm_ff;
    assign power_class        = pwr_ff;

    ////////////////////////////////////////////////////////////////////////////////////////
    // assertions
    AST_SEL_ONLY: assert property (@(posedge clk) disable iff (!reset_n)
        ser_ack |-> $past(!module_select_n))
        else $error("command answered while not selected");
    AST_RESET_DEFAULT: assert property (@(posedge clk) disable iff (!reset_n)
        state_ff == MSC_ST_HOLD |=> soft_txdis_ff == '0 && !hipwr_ff)
        else $error("settings not defaulted during reset");
    AST_SHORT_IGNORED: assert property (@(posedge clk) disable iff (!reset_n)
        state_ff == MSC_ST_RUN && !long_low |=> state_ff != MSC_ST_HOLD)
        else $error("short reset pulse acted");
    AST_DONE_INT: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(dnr_ff) |-> done_int_ff && interrupt_oe)
        else $error("completion without interrupt");
    AST_POWERUP: assert property (@(posedge clk) disable iff (!reset_n)
        state_ff == MSC_ST_POWERUP |-> ##[1:300] !dnr_ff)
        else $error("no completion after power-up");
    AST_LOWPWR: assert property (@(posedge clk) disable iff (!reset_n)
        low_power_select |=> power_class == `MSC_LOW_POWER_CLASS)
        else $error("power not limited in low-power mode");
    AST_TXDIS: assert property (@(posedge clk) disable iff (!reset_n)
        transmit_disable |=> tx_off == '1)
        else $error("transmitter not disabled by pin");
    AST_LOS: assert property (@(posedge clk) disable iff (!reset_n)
        |lane_lost |=> receive_loss_alarm)
        else $error("loss alarm missing");
    AST_PRESENT: assert property (@(posedge clk) disable iff (!reset_n)
        !module_present_n)
        else $error("presence not low");
    AST_FAULT_INT: assert property (@(posedge clk) disable iff (!reset_n)
        fault_in && state_ff == MSC_ST_RUN |=> interrupt_oe)
        else $error("fault did not raise interrupt");
    AST_LOS_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
        !(|lane_lost) |=> !receive_loss_alarm)
        else $error("loss alarm without lost lane");
    AST_SOFT_TXDIS: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> (tx_off & $past(soft_txdis_ff)) == $past(soft_txdis_ff))
        else $error("serial tx disable ignored");
    AST_MON_VALUE: assert property (@(posedge clk) disable iff (!reset_n)
        state_ff != MSC_ST_POWERUP |=> diagnostic_monitor == $past(lane_level))
        else $error("monitored value not refreshed");
    COV_RESET: cover property (@(posedge clk) disable iff (!reset_n)
        state_ff == MSC_ST_HOLD ##1 state_ff == MSC_ST_INIT);
    COV_WRITE: cover property (@(posedge clk) disable iff (!reset_n)
        ser_ack && $past(ser_wr_stb));
    COV_LOS: cover property (@(posedge clk) disable iff (!reset_n) $rose(receive_loss_alarm));
    COV_FAULT: cover property (@(posedge clk) disable iff (!reset_n)
        fault_int_ff ##1 !fault_int_ff);
    COV_READY: cover property (@(posedge clk) disable iff (!reset_n)
        $fell(data_not_ready) ##1 interrupt_oe);
endmodule
`default_nettype wire

// ==== test/msc_host_model.sv ====
// host controller model: select line, decoded serial strobes and the pulled-up interrupt line
`timescale 1ns/1ps
`default_nettype none
module msc_host_model (
    input  wire logic       clk,              // system clock
    input  wire logic       interrupt_n,      // module interrupt level
    input  wire logic       interrupt_oe,     // module pulls the line
    input  wire logic       ser_ack,          // module accepted a strobe
    output var logic        module_select_n,  // this module's own select line
    output var logic        ser_wr_stb,       // serial write pulse
    output var logic        ser_rd_stb,       // serial read pulse
    output var logic  [4:0] ser_wdata,        // serial write data
    output var logic        ser_int_clr,      // clear of interrupt causes
    output var logic        acked,            // ack seen on the last access
    output wire logic       int_line          // resolved interrupt line
);
    // open-drain line with the host pull-up
    assign int_line = interrupt_oe ? interrupt_n : 1'h1;

    initial begin
        module_select_n = 1'h1;
        ser_wr_stb      = 1'h0;
        ser_rd_stb      = 1'h0;
        ser_wdata       = 5'h00;
        ser_int_clr     = 1'h0;
        acked           = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one access; sel low leaves the line deselected, wr low sends a read pulse in place
    // of the write, and every access returns the select line to idle high
    task automatic access(input logic sel, input logic wr, input logic [4:0] d,
                          input logic clr);
        @(posedge clk);
        module_select_n <= ~sel;
        ser_wr_stb      <= wr;
        ser_rd_stb      <= ~wr;
        ser_wdata       <= d;
        ser_int_clr     <= clr;
        @(posedge clk);
        ser_wr_stb      <= 1'h0;
        ser_rd_stb      <= 1'h0;
        ser_int_clr     <= 1'h0;
        @(negedge clk);
        acked = ser_ack;
        @(posedge clk);
        module_select_n <= 1'h1;
    endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench of the module sideband control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import msc_pkg::*;
    logic        clk = 1'h0;
    logic        reset_n = 1'h0;
    logic        module_reset_n = 1'h1;
    logic        low_power_select = 1'h1;
    logic        transmit_disable = 1'h0;
    logic [31:0] lane_level = 32'h8080_8080;
    logic [7:0]  loss_threshold = 8'h40;
    logic        fault_in = 1'h0;
    wire logic   sel_n, wr_stb, rd_stb, int_clr, ser_ack, dnr, present_n;
    wire logic   int_n, int_oe, loss_alarm, acked, int_line;
    wire logic [4:0]  wdata;
    wire logic [31:0] monitor;
    wire logic [7:0]  status;
    wire logic [3:0]  tx_off;
    msc_pwr_t    power_class;
    int          n_fail = 0;
    int          checks_done = 0;

    always #5 clk = ~clk;

    msc_sideband #(.RESET_CYC(8), .INIT_CYC(4)) uut (
        .clk(clk), .reset_n(reset_n), .module_select_n(sel_n),
        .module_reset_n(module_reset_n), .low_power_select(low_power_select),
        .transmit_disable(transmit_disable), .ser_wr_stb(wr_stb), .ser_rd_stb(rd_stb),
        .ser_wdata(wdata), .ser_int_clr(int_clr), .lane_level(lane_level),
        .loss_threshold(loss_threshold), .fault_in(fault_in), .ser_ack(ser_ack),
        .diagnostic_monitor(monitor), .ser_status(status), .data_not_ready(dnr),
        .module_present_n(present_n), .interrupt_n(int_n), .interrupt_oe(int_oe),
        .tx_off(tx_off), .receive_loss_alarm(loss_alarm), .power_class(power_class));

    msc_host_model host (
        .clk(clk), .interrupt_n(int_n), .interrupt_oe(int_oe), .ser_ack(ser_ack),
        .module_select_n(sel_n), .ser_wr_stb(wr_stb), .ser_rd_stb(rd_stb),
        .ser_wdata(wdata), .ser_int_clr(int_clr), .acked(acked), .int_line(int_line));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    // bounded wait for the interrupt line to go low
    task automatic wait_int();
        for (int i = 0; i < 40; i++) begin
            if (int_line === 1'h0) break;
            step(1);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #50000;
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'h1;
        wait_int();
        chk(int_line, 1'h0);
        step(1);
        chk({dnr, status[6]}, 2'h1);
        chk(present_n, 1'h0);
        host.access(1'h0, 1'h1, 5'h05, 1'h0);
        step(3);
        chk({acked, tx_off}, 5'h00);
        host.access(1'h1, 1'h1, 5'h05, 1'h0);
        step(2);
        chk({acked, tx_off}, 5'h15);
        @(posedge clk) transmit_disable <= 1'h1;
        step(3);
        chk(tx_off, 4'hf);
        @(posedge clk) transmit_disable <= 1'h0;
        step(3);
        chk(tx_off, 4'h5);
        host.access(1'h1, 1'h1, 5'h15, 1'h0);
        step(3);
        chk(power_class, 2'h0);
        @(posedge clk) low_power_select <= 1'h0;
        step(3);
        chk(power_class, 2'h3);
        host.access(1'h1, 1'h0, 5'h00, 1'h1);
        step(3);
        chk(int_line, 1'h1);
        @(posedge clk) lane_level <= 32'h8020_8080;
        step(4);
        chk({loss_alarm, status[3:0]}, 5'h14);
        chk(monitor, 32'h8020_8080);
        chk({int_line, status[5]}, 2'h1);
        @(posedge clk) lane_level <= 32'h8040_8080;
        step(3);
        chk({loss_alarm, status[3:0]}, 5'h00);
        host.access(1'h1, 1'h0, 5'h00, 1'h1);
        @(posedge clk) fault_in <= 1'h1;
        step(3);
        chk({int_line, status[5]}, 2'h1);
        @(posedge clk) fault_in <= 1'h0;
        host.access(1'h1, 1'h0, 5'h00, 1'h1);
        step(3);
        chk(int_line, 1'h1);
        @(posedge clk) module_reset_n <= 1'h0;
        repeat (4) @(posedge clk);
        module_reset_n <= 1'h1;
        step(10);
        chk({tx_off, power_class, dnr}, 7'h2e);
        @(posedge clk) module_reset_n <= 1'h0;
        repeat (12) @(posedge clk);
        step(1);
        chk({dnr, int_line}, 2'h3);
        @(posedge clk) module_reset_n <= 1'h1;
        step(1);
        wait_int();
        chk({int_line, dnr}, 2'h0);
        step(1);
        chk({tx_off, power_class}, 6'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
